// >>> common/error_flag_pkg.sv
// Types shared by the error-flag reporting block.
// Assumes the constants header sits in the include path.
`include "error_flag_regs.svh"

package error_flag_pkg;

    // Which query the controller issues
    typedef enum logic [2:0] {
        QRY_IDLE = 3'b001,
        QRY_SUMMARY = 3'b010,
        QRY_TEXT = 3'b100
    } query_t;

    // Answer to a text query
    typedef struct packed {
        logic fromAux;
        logic [`CODE_WIDTH-1:0] code;
        logic [`IDX_WIDTH-1:0] bitIndex;
    } text_answer_t;

    // Answer to a summary query
    typedef struct packed {
        logic [`SUM_WIDTH-1:0] weightedSum;
    } summary_answer_t;

endpackage

// >>> common/error_flag_regs.svh
// Constants for the error-flag reporting block: widths, bit positions, reset values, codes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ERROR_FLAG_REGS_SVH
`define ERROR_FLAG_REGS_SVH

`define FLAG_WIDTH 15
`define AUX_WIDTH 16
`define IDX_WIDTH 4
`define SUM_WIDTH 16
`define CODE_WIDTH 9
`define FLAG_RESET 15'h0000
`define AUX_RESET 16'h0000
`define MASK_RESET 15'h7fff
`define AUX_SUMMARY_BIT 0
`define STATUS_ERR_BIT 5
`define FLAG_CODE_BASE 9'h064
`define AUX_CODE_BASE 9'h0c8
`define NO_ERROR_CODE 9'h000
`define MAX_TEXT_LEN 8'hff

`endif

// >>> core/error_flag_reporting.sv
// Error-flag register, auxiliary error register and the two drain queries.
// Auxiliary leftovers survive a summary query and stay readable by text query.
// Assumes error and query strobes are one-cycle pulses from logic on clk;
// fault mask writes come from the command decoder on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "error_flag_regs.svh"

module error_flag_reporting (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Error events, one bit per class
    input wire logic [`FLAG_WIDTH-1:0] flagEvent,
    input wire logic [`AUX_WIDTH-1:0] auxEvent,
    // Fault enable mask write
    input wire logic maskWrite,
    input wire logic [`FLAG_WIDTH-1:0] maskData,
    // Queries
    input wire error_flag_pkg::query_t query,
    // Answers
    output error_flag_pkg::summary_answer_t summaryAnswer,
    output error_flag_pkg::text_answer_t textAnswer,
    output logic summaryValid,
    output logic textValid,
    output logic [7:0] textMaxLen,
    // State visible to the rest of the instrument
    output logic [`FLAG_WIDTH-1:0] errorFlags,
    output logic [`AUX_WIDTH-1:0] auxFlags,
    output logic [`FLAG_WIDTH-1:0] faultEnableMask,
    output logic statusErrBit,
    output logic errLamp
);
    import error_flag_pkg::*;

    // Reset synchroniser; only rstSync feeds the design
    logic rstMeta;
    logic rstSync;

    // Error-flag register: one sticky bit per error class
    logic [`FLAG_WIDTH-1:0] flag_reg;
    logic [`FLAG_WIDTH-1:0] flag_next;
    // Auxiliary detail register, summarised by flag bit 0
    logic [`AUX_WIDTH-1:0] aux_reg;
    logic [`AUX_WIDTH-1:0] aux_next;
    // Fault enable mask; gates the status bit only
    logic [`FLAG_WIDTH-1:0] mask_reg;
    logic [`FLAG_WIDTH-1:0] mask_next;
    // Error summary bit of the status register
    logic status_reg;
    logic status_next;
    // Registered answers and their one-cycle valid pulses
    summary_answer_t sum_reg;
    summary_answer_t sum_next;
    text_answer_t text_reg;
    text_answer_t text_next;
    logic sumValid_reg;
    logic sumValid_next;
    logic textValid_reg;
    logic textValid_next;
    // Front-panel error indicator, kept in a flop so no logic sits on the pin
    logic lamp_reg;
    logic lamp_next;
    // String length limit handed to the text formatter
    logic [7:0] lenLimit_reg;
    logic [7:0] lenLimit_next;

    // Clear requests raised by the queries, one bit per register bit
    logic [`FLAG_WIDTH-1:0] flagClr;
    logic [`AUX_WIDTH-1:0] auxClr;
    // New errors that the mask lets through to the status bit
    logic [`FLAG_WIDTH-1:0] enabledNew;
    // Decoded query strobes
    logic isSummary;
    logic isText;

    // Priority encoder results
    logic auxFound;
    logic [3:0] auxIdx;
    logic flagFound;
    logic [3:0] flagIdx;

    // Weighted sum of set bits; bit i already weighs 2**i
    function automatic logic [`SUM_WIDTH-1:0] weigh(input logic [`FLAG_WIDTH-1:0] f);
        weigh = {1'b0, f};
    endfunction

    // Query decode for the status group strobes; the answer group cases on query itself
    function automatic logic queryIs(input query_t q, input query_t want);
        queryIs = (q == want);
    endfunction

    // Release reset through two flops, assert asynchronously
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Lowest pending auxiliary bit
    lowest_set_finder #(.WIDTH(`AUX_WIDTH)) auxFinder (
        .vec(aux_reg),
        .found(auxFound),
        .index(auxIdx)
    );

    // Lowest pending flag bit; bit 0 alone reports as a plain hardware fault
    lowest_set_finder #(.WIDTH(`FLAG_WIDTH)) flagFinder (
        .vec(flag_reg),
        .found(flagFound),
        .index(flagIdx)
    );

    // Query decode; one strobe per kind of query
    always_comb begin
        isSummary = queryIs(query, QRY_SUMMARY);
        isText = queryIs(query, QRY_TEXT);
    end

    // Answer group: capture the answer and raise the clear requests
    // Both answers are registered, so the host sees them one cycle after the query
    always_comb begin
        flagClr = '0;
        auxClr = '0;
        sum_next = sum_reg;
        text_next = text_reg;
        sumValid_next = 1'b0;
        textValid_next = 1'b0;
        unique case (query)
            QRY_IDLE: begin
                // Nothing asked; answers hold
            end
            QRY_SUMMARY: begin
                // Sum is taken before the clear lands, so it shows what was pending
                sum_next.weightedSum = weigh(flag_reg);
                flagClr = '1;
                sumValid_next = 1'b1;
            end
            QRY_TEXT: begin
                textValid_next = 1'b1;
                if (auxFound) begin
                    // Auxiliary detail first whenever any is pending
                    text_next.fromAux = 1'b1;
                    text_next.bitIndex = auxIdx;
                    text_next.code = `AUX_CODE_BASE + `CODE_WIDTH'(auxIdx);
                    auxClr[auxIdx] = 1'b1;
                    // Last detail bit read: the summary bit goes with it
                    if ((aux_reg & ~auxClr) == '0) begin
                        flagClr[`AUX_SUMMARY_BIT] = 1'b1;
                    end
                end else if (flagFound) begin
                    // Flag bits only once no detail is left
                    text_next.fromAux = 1'b0;
                    text_next.bitIndex = flagIdx;
                    text_next.code = `FLAG_CODE_BASE + `CODE_WIDTH'(flagIdx);
                    flagClr[flagIdx] = 1'b1;
                end else begin
                    // Both registers empty: the no-error answer
                    text_next.fromAux = 1'b0;
                    text_next.bitIndex = 4'h0;
                    text_next.code = `NO_ERROR_CODE;
                end
            end
            default: begin
                // Illegal query code ignored, nothing shown
            end
        endcase
    end

    // Flag group: set beats clear, and flags set whatever the mask says
    // A level held on an event input simply re-sets its bit every cycle
    always_comb begin
        aux_next = (aux_reg & ~auxClr) | auxEvent;
        flag_next = (flag_reg & ~flagClr) | flagEvent;
        // New detail raises the summary bit, even over a clear
        flag_next[`AUX_SUMMARY_BIT] = flag_next[`AUX_SUMMARY_BIT] | (|auxEvent);
        // Lamp follows the next flags so it lands together with them
        lamp_next = |flag_next;
    end

    // Mask group: loaded by the command decoder
    // A write landing with an event still gates that event with the old mask
    always_comb begin
        mask_next = maskWrite ? maskData : mask_reg;
    end

    // Status group: error summary bit of the status register
    // Clears are applied first and new enabled errors last, so a new error is never lost
    always_comb begin
        // Auxiliary events count under mask bit 0, like the class they detail
        enabledNew = (flagEvent | {{(`FLAG_WIDTH-1){1'b0}}, |auxEvent}) & mask_reg;
        status_next = status_reg;
        if (isSummary) begin
            // Summary query drops the bit outright
            status_next = 1'b0;
        end else if (isText && flag_next == '0 && aux_next == '0) begin
            // Text query drops it only once both registers are empty
            status_next = 1'b0;
        end
        if (|enabledNew) begin
            status_next = 1'b1;
        end
    end

    // Length limit group: a fixed figure, held in a flop like every other output
    always_comb begin
        lenLimit_next = `MAX_TEXT_LEN;
    end

    // Flag group registers
    // Reset runs off the synchronised copy, so its release is clean
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            flag_reg <= `FLAG_RESET;
            aux_reg <= `AUX_RESET;
            lamp_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            aux_reg <= aux_next;
            lamp_reg <= lamp_next;
        end
    end

    // Answer group registers
    // Answers hold between queries; only the valid pulses drop
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            sum_reg <= '0;
            text_reg <= '0;
            sumValid_reg <= 1'b0;
            textValid_reg <= 1'b0;
        end else begin
            sum_reg <= sum_next;
            text_reg <= text_next;
            sumValid_reg <= sumValid_next;
            textValid_reg <= textValid_next;
        end
    end

    // Mask group register; every class enabled after reset
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            mask_reg <= `MASK_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // Status group register
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            status_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
        end
    end

    // Length limit register
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            lenLimit_reg <= `MAX_TEXT_LEN;
        end else begin
            lenLimit_reg <= lenLimit_next;
        end
    end

    // Outputs straight from flops
    // No gate sits between a register and its pin
    assign summaryAnswer = sum_reg;
    assign textAnswer = text_reg;
    assign summaryValid = sumValid_reg;
    assign textValid = textValid_reg;
    assign textMaxLen = lenLimit_reg;
    assign errorFlags = flag_reg;
    assign auxFlags = aux_reg;
    assign faultEnableMask = mask_reg;
    assign statusErrBit = status_reg;
    assign errLamp = lamp_reg;

endmodule

`default_nettype wire

// >>> core/lowest_set_finder.sv
// Priority encoder: finds the lowest set bit of a vector.
// Assumes a purely combinational use by the reporting core.
`timescale 1ns/100ps
`default_nettype none

module lowest_set_finder #(
    parameter int WIDTH = 16
) (
    // Vector under search
    input wire logic [WIDTH-1:0] vec,
    // Result
    output logic found,
    output logic [3:0] index
);

    // Scan from the top so the lowest set bit is written last and wins
    always_comb begin
        found = 1'b0;
        index = 4'h0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                index = 4'(i);
            end
        end
    end

endmodule

`default_nettype wire

// >>> tb/error_flag_monitor.sv
// Port checker for the error-flag block.
// Assumes binding onto error_flag_reporting.
`timescale 1ns/100ps
`default_nettype none
module error_flag_monitor
    import error_flag_pkg::*;
(
    // Clock, reset, inputs
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [14:0] flagEvent,
    input wire logic [15:0] auxEvent,
    input wire query_t query,
    // Outputs watched
    input wire summary_answer_t summaryAnswer,
    input wire text_answer_t textAnswer,
    input wire logic summaryValid,
    input wire logic textValid,
    input wire logic [7:0] textMaxLen,
    input wire logic [14:0] errorFlags,
    input wire logic statusErrBit,
    input wire logic errLamp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // No event this cycle, so a clear must stick
    wire logic calm = flagEvent == 0 && auxEvent == 0;
    a_summary_answer_late: assert property (query == QRY_SUMMARY |=> summaryValid)
        else $error("summary answer late");
    a_text_answer_late: assert property (query == QRY_TEXT |=> textValid)
        else $error("text answer late");
    a_summary_weighted_sum: assert property (query == QRY_SUMMARY |=>
        summaryAnswer.weightedSum == {1'b0, $past(errorFlags)}) else $error("bad sum");
    a_summary_clears_all: assert property (query == QRY_SUMMARY && calm |=>
        errorFlags == 0 && !statusErrBit) else $error("summary left state");
    a_event_sets_flag: assert property (flagEvent != 0 |=>
        (errorFlags & $past(flagEvent)) == $past(flagEvent)) else $error("event lost");
    a_aux_sets_summary: assert property (auxEvent != 0 |=> errorFlags[0])
        else $error("aux summary bit low");
    a_lamp_follows_flags: assert property (errLamp == (errorFlags != 0))
        else $error("lamp wrong");
    a_text_code_series: assert property (textValid |-> textAnswer.code == 0 ||
        textAnswer.code == (textAnswer.fromAux ? 9'h0c8 : 9'h064) + textAnswer.bitIndex)
        else $error("bad code");
    a_text_length_limit: assert property (textMaxLen == 8'hff)
        else $error("length limit");
    // Main scenarios
    c_aux_text: cover property (textValid && textAnswer.fromAux);
    c_no_error: cover property (textValid && textAnswer.code == 0);
    c_sum_set: cover property (summaryValid && summaryAnswer.weightedSum != 0);
endmodule
bind error_flag_reporting error_flag_monitor mon_u (.clk, .rst_n, .flagEvent, .auxEvent,
    .query, .summaryAnswer, .textAnswer, .summaryValid, .textValid, .textMaxLen,
    .errorFlags, .statusErrBit, .errLamp);
`default_nettype wire

// >>> tb/error_flag_reporting_tb_top.sv
// Bench: summary table, then text drain, host drain, mask, races.
// Assumes package and host model compiled first.
`timescale 1ns/100ps
`default_nettype none
module error_flag_reporting_tb_top;
    import error_flag_pkg::*;
    logic clk = 0, rst_n = 0, maskWrite = 0, start = 0, hostBusy;
    logic [14:0] flagEvent = 0, maskData = 0, errorFlags, faultEnableMask;
    logic [15:0] auxEvent = 0, auxFlags;
    query_t tbQuery = QRY_IDLE, hostQuery;
    summary_answer_t summaryAnswer;
    text_answer_t textAnswer;
    logic summaryValid, textValid, statusErrBit, errLamp;
    logic [7:0] textMaxLen;
    logic [4:0] nRead;
    int n_mismatch = 0, num_checks = 0;
    // Events beside weighted sums; codes beside flags left
    logic [30:0] rows [6] = '{{15'h0000, 16'h0000}, {15'h000f, 16'h000f}, {15'h00f0, 16'h00f0},
        {15'h0f00, 16'h0f00}, {15'h7000, 16'h7000}, {15'h7fff, 16'h7fff}};
    logic [23:0] drain [5] = '{{9'h0ca, 15'h0089}, {9'h0cd, 15'h0088}, {9'h067, 15'h0080},
        {9'h06b, 15'h0000}, {9'h000, 15'h0000}};
    always #2 clk = ~clk;
    error_flag_reporting dut_u (.clk, .rst_n, .flagEvent, .auxEvent, .maskWrite, .maskData,
        .query(hostBusy ? hostQuery : tbQuery), .summaryAnswer, .textAnswer, .summaryValid,
        .textValid, .textMaxLen, .errorFlags, .auxFlags, .faultEnableMask, .statusErrBit, .errLamp);
    remote_host_model host_u (.clk, .start, .textValid, .textAnswer, .query(hostQuery),
        .busy(hostBusy), .nRead);
    task chk(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task ev(input logic [14:0] f, input logic [15:0] a);
        @(posedge clk) flagEvent <= f;
        auxEvent <= a;
        @(posedge clk) flagEvent <= 0;
        auxEvent <= 0;
    endtask
    // Query held one cycle; answer sampled once settled
    task qry(input query_t q);
        @(posedge clk) tbQuery <= q;
        @(posedge clk) tbQuery <= QRY_IDLE;
        #1;
    endtask
    task report_and_stop;
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        #1 chk("mask", 16'(faultEnableMask), 16'h7fff);
        chk("limit", 16'(textMaxLen), 16'h00ff);
        foreach (rows[i]) begin
            ev(rows[i][30:16], 0);
            qry(QRY_SUMMARY);
            chk("sum", summaryAnswer.weightedSum, rows[i][15:0]);
            chk("cleared", {errLamp, errorFlags}, 0);
        end
        ev(15'h0088, 16'h0024);
        #1 chk("status", 16'(statusErrBit), 1);
        foreach (drain[i]) begin
            qry(QRY_TEXT);
            chk("code", 16'(textAnswer.code), 16'(drain[i][23:15]));
            chk("flags", 16'(errorFlags), 16'(drain[i][14:0]));
        end
        chk("status", 16'(statusErrBit), 0);
        chk("aux", auxFlags, 0);
        ev(15'h0006, 16'h0001);
        @(posedge clk) start <= 1;
        @(posedge clk) start <= 0;
        // Busy rises in this edge's update, so one edge passes before polling it
        @(posedge clk);
        for (int k = 0; k < 40 && hostBusy; k++) @(posedge clk);
        #1 chk("host done", 16'(hostBusy), 0);
        chk("reads", 16'(nRead), 3);
        @(posedge clk) maskWrite <= 1;
        @(posedge clk) maskWrite <= 0;
        ev(15'h0004, 0);
        #1 chk("masked", {statusErrBit, errorFlags}, 16'h0004);
        @(posedge clk) maskWrite <= 1;
        maskData <= 15'h7fff;
        @(posedge clk) maskWrite <= 0;
        // Event lands on the same edge as the clearing query
        @(posedge clk) tbQuery <= QRY_SUMMARY;
        flagEvent <= 15'h0010;
        @(posedge clk) tbQuery <= QRY_IDLE;
        flagEvent <= 0;
        #1 chk("sum", summaryAnswer.weightedSum, 16'h0004);
        chk("kept", {statusErrBit, errorFlags}, 16'h8010);
        qry(QRY_SUMMARY);
        chk("status", 16'(statusErrBit), 0);
        report_and_stop();
    end
    // Run needs under 200 cycles
    initial begin
        #4000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> tb/remote_host_model.sv
// Remote controller: drains faults by repeated text queries.
// Assumes answers come one cycle after each query.
`timescale 1ns/100ps
`default_nettype none
module remote_host_model
    import error_flag_pkg::*;
(
    // Clock and start
    input wire logic clk,
    input wire logic start,
    // Answer side
    input wire logic textValid,
    input wire text_answer_t textAnswer,
    // Query side
    output var query_t query = QRY_IDLE,
    output var logic busy = 0,
    output var logic [4:0] nRead = 0
);
    // One query in flight; never issues before the answer lands
    always @(posedge clk) begin
        query <= QRY_IDLE;
        if (start && !busy) begin
            busy <= 1;
            nRead <= 0;
            query <= QRY_TEXT;
        end else if (busy && textValid) begin
            if (textAnswer.code == 9'h000)
                busy <= 0;
            else begin
                nRead <= nRead + 5'h01;
                query <= QRY_TEXT;
            end
        end
    end
endmodule
`default_nettype wire
